// *** src/ssq_sequencer.sv ***
// Purpose: core reset release, startup checks, bit clocks and flag pins
// Assumes: reference clock and reset pin sampled by the core clock
// Notes: registers over APB with one wait state on every access
`timescale 1ns/1ps
`include "ssq_params.svh"

module ssq_sequencer import ssq_pkg::*; #(
	parameter int STRAP_SETUP_CYC = `SSQ_STRAP_SETUP_CYC,
	parameter int CLK_VALID_CYC = `SSQ_CLK_VALID_CYC,
	parameter int PLL_LOCK_CYC = `SSQ_PLL_LOCK_CYC,
	parameter int N_AUDIO_IRQ = 1
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// board pins
	input wire logic RESET_PIN_N,
	input wire logic REF_CLK_IN,
	input wire logic [1:0] CLOCK_RATIO_STRAPS,
	input wire logic [2:0] IRQ_FLAG_IN,
	input wire logic [N_AUDIO_IRQ-1:0] AUDIO_IRQ_IN,
	// flag pin 3, two-way
	input wire logic GENERAL_FLAG_PIN_3_I,
	output logic GENERAL_FLAG_PIN_3_O,
	output logic GENERAL_FLAG_PIN_3_OE,
	// core side
	input wire logic CORE_TIMER_IN,
	output logic CORE_RESET,
	output logic [2+N_AUDIO_IRQ:0] IRQ_REQ,
	output logic SERIAL_BIT_CLK,
	output logic SPI_BIT_CLK,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	generate
		if (N_AUDIO_IRQ < 1 || STRAP_SETUP_CYC < 1 || CLK_VALID_CYC < 1 ||
			PLL_LOCK_CYC < 1) begin : g_chk
			$error("ssq_sequencer parameters out of range");
		end
	endgenerate

	localparam int NI = 3 + N_AUDIO_IRQ;
	localparam int LW = $clog2(PLL_LOCK_CYC + 1) + 1;
	localparam logic [LW-1:0] STRAP_LIM = LW'(STRAP_SETUP_CYC);
	localparam logic [LW-1:0] CLKV_LIM = LW'(CLK_VALID_CYC);
	localparam logic [LW-1:0] LOCK_LIM = LW'(PLL_LOCK_CYC);
	localparam logic [7:0] GAP_LIM = 8'(2 * `SSQ_REF_MAX_CYC);

	// pin synchronisers
	logic [1:0] rst_m, rst_s, ref_m, ref_s;
	logic [1:0] strap_m, strap_s, strap_q;
	logic [NI-1:0] irq_m, irq_s, irq_q;
	logic f3_m, f3_s;
	always_ff @(posedge CORE_CLK) begin
		rst_m <= {rst_m[0], RESET_PIN_N};
		ref_m <= {ref_m[0], REF_CLK_IN};
		strap_m <= CLOCK_RATIO_STRAPS;
		strap_s <= strap_m;
		irq_m <= {AUDIO_IRQ_IN, IRQ_FLAG_IN};
		irq_s <= irq_m;
		f3_m <= GENERAL_FLAG_PIN_3_I;
		f3_s <= f3_m;
	end
	assign rst_s = rst_m;
	assign ref_s = ref_m;

	// history flops behind the second stage
	logic ref_q;
	always_ff @(posedge CORE_CLK) begin
		ref_q <= ref_s[1];
		strap_q <= strap_s;
		irq_q <= irq_s;
	end

	wire ref_fall = ref_q & ~ref_s[1];
	wire ref_rise = ~ref_q & ref_s[1];
	wire strap_chg = strap_q != strap_s;

	// reset pin taken only at reference falling edges
	logic rst_asserted;
	always_ff @(posedge CORE_CLK) begin
		if (RST)
			rst_asserted <= 1'b1;
		else if (ref_fall)
			rst_asserted <= ~rst_s[1];
	end

	// release sequencer
	ssq_state_e state, next_state;
	logic [12:0] rel_cnt;
	logic [2:0] pulse_cnt;
	logic powered;
	wire release_evt = state == SSQ_HELD && !rst_asserted;
	wire count_done = rel_cnt == `SSQ_RELEASE_REF_CYC - 13'h0001;

	always_comb begin
		next_state = state;
		unique case (state)
			SSQ_HELD:
				if (!rst_asserted)
					next_state = SSQ_COUNT;
			SSQ_COUNT:
				if (rst_asserted)
					next_state = SSQ_HELD;
				else if (ref_rise && count_done)
					next_state = SSQ_RUN;
			SSQ_RUN:
				if (rst_asserted)
					next_state = SSQ_HELD;
		endcase
	end

	// count reference rising edges after a sampled release
	always_ff @(posedge CORE_CLK) begin
		if (RST || state != SSQ_COUNT || rst_asserted)
			rel_cnt <= '0;
		else if (ref_rise)
			rel_cnt <= rel_cnt + 13'h0001;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state <= SSQ_HELD;
			CORE_RESET <= 1'b1;
			powered <= 1'b0;
		end else begin
			state <= next_state;
			CORE_RESET <= next_state != SSQ_RUN;
			if (next_state == SSQ_RUN)
				powered <= 1'b1;
		end
	end

	// reset pulse width in reference cycles, saturating
	always_ff @(posedge CORE_CLK) begin
		if (RST || !rst_asserted)
			pulse_cnt <= '0;
		else if (ref_fall && pulse_cnt != 3'h7)
			pulse_cnt <= pulse_cnt + 3'h1;
	end

	// timers in core cycles: strap stability, clock validity, reset length
	logic [LW-1:0] strap_cnt, clkv_cnt, held_cnt;
	logic [7:0] gap_cnt;
	always_ff @(posedge CORE_CLK) begin
		if (RST || strap_chg)
			strap_cnt <= '0;
		else if (strap_cnt != STRAP_LIM)
			strap_cnt <= strap_cnt + LW'(1);
		if (RST || ref_rise)
			gap_cnt <= '0;
		else if (gap_cnt != GAP_LIM)
			gap_cnt <= gap_cnt + 8'h01;
		if (RST || gap_cnt == GAP_LIM)
			clkv_cnt <= '0;
		else if (clkv_cnt != CLKV_LIM)
			clkv_cnt <= clkv_cnt + LW'(1);
		if (RST || !rst_asserted || gap_cnt == GAP_LIM)
			held_cnt <= '0;
		else if (held_cnt != LOCK_LIM)
			held_cnt <= held_cnt + LW'(1);
	end

	// error events at the sampled release
	ssq_err_s err, err_set, err_clr;
	assign err_set.short_pulse = release_evt && powered &&
		pulse_cnt < `SSQ_MIN_PULSE_REF_CYC;
	assign err_set.strap_late = release_evt && strap_cnt != STRAP_LIM;
	assign err_set.clk_late = release_evt && clkv_cnt != CLKV_LIM;
	assign err_set.pll_short = release_evt && !powered &&
		held_cnt != LOCK_LIM;

	// APB decode
	wire acc = PSEL && PENABLE && !PREADY;
	wire wr = acc && PWRITE;
	wire hit_pm = PADDR == `SSQ_OFS_POWER_MGMT_CONTROL_REGISTER;
	wire hit_spi = PADDR == `SSQ_OFS_SPIDIV;
	wire hit_ser = PADDR == `SSQ_OFS_SERDIV;
	wire hit_flg = PADDR == `SSQ_OFS_FLAGCTL;
	wire hit_st = PADDR == `SSQ_OFS_STATUS;
	wire hit_rt = PADDR == `SSQ_OFS_RATIO;
	wire mapped = hit_pm | hit_spi | hit_ser | hit_flg | hit_st | hit_rt;
	assign err_clr = (wr && hit_st) ? ssq_err_s'(PWDATA[4:1]) : '0;

	// sticky errors, a new event wins over a write-one clear
	always_ff @(posedge CORE_CLK) begin
		if (RST)
			err <= '0;
		else
			err <= err_set | (err & ~err_clr);
	end

	// straps pick the default multiplier
	logic [7:0] strap_mult;
	assign strap_mult = (strap_s == 2'b00) ? `SSQ_MULT_00 :
		(strap_s == 2'b01) ? `SSQ_MULT_01 : `SSQ_MULT_1X;

	// software registers
	ssq_power_mgmt_control_register_s pm;
	logic [15:0] spi_div, ser_div;
	logic [2:0] flag_ctl;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pm <= '0;
			pm.pll_divider <= `SSQ_RST_PLL_DIVIDER;
			spi_div <= `SSQ_RST_SPIDIV;
			ser_div <= `SSQ_RST_SERDIV;
			flag_ctl <= '0;
		end else if (state != SSQ_RUN) begin
			pm.pll_multiplier <= strap_mult;
		end else if (wr) begin
			if (hit_pm)
				pm <= ssq_power_mgmt_control_register_s'({19'h0_0000, PWDATA[12:0]});
			if (hit_spi)
				spi_div <= PWDATA[15:0];
			if (hit_ser)
				ser_div <= PWDATA[15:0];
			if (hit_flg)
				flag_ctl <= PWDATA[2:0];
		end
	end

	// ratio readback: VCO over reference and core divisor
	logic [15:0] vco_mult, core_div;
	assign vco_mult = pm.in_div ? {8'h00, pm.pll_multiplier} :
		{7'h00, pm.pll_multiplier, 1'b0};
	assign core_div = {11'h000, pm.pll_divider, 1'b0};

	logic [31:0] rdata;
	assign rdata = hit_pm ? 32'(pm) :
		hit_spi ? {16'h0000, spi_div} :
		hit_ser ? {16'h0000, ser_div} :
		hit_flg ? {29'h0000_0000, flag_ctl} :
		hit_st ? {26'h000_0000, f3_s, err, CORE_RESET} :
		hit_rt ? {core_div, vco_mult} : 32'h0000_0000;

	// one wait state, then a one-cycle ready
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= acc;
			PSLVERR <= acc && !mapped;
			PRDATA <= (acc && !PWRITE) ? rdata : 32'h0000_0000;
		end
	end

	// interrupt requests only after two cycles of level
	always_ff @(posedge CORE_CLK) begin
		if (RST)
			IRQ_REQ <= '0;
		else
			IRQ_REQ <= irq_s & irq_q;
	end

	// flag pin 3: core timer or plain flag
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			GENERAL_FLAG_PIN_3_O <= 1'b0;
			GENERAL_FLAG_PIN_3_OE <= 1'b0;
		end else begin
			GENERAL_FLAG_PIN_3_O <= flag_ctl[0] ? CORE_TIMER_IN : flag_ctl[2];
			GENERAL_FLAG_PIN_3_OE <= flag_ctl[0] | flag_ctl[1];
		end
	end

	// bit clocks as whole multiples of the core period
	ssq_bitclk_div #(.W(16)) u_ser_div (
		.clk(CORE_CLK),
		.rst(RST),
		.ratio(ser_div),
		.bit_clk(SERIAL_BIT_CLK)
	);
	ssq_bitclk_div #(.W(16)) u_spi_div (
		.clk(CORE_CLK),
		.rst(RST),
		.ratio(spi_div),
		.bit_clk(SPI_BIT_CLK)
	);
endmodule // ssq_sequencer

// *** src/ssq_params.svh ***
// Purpose: constants of the startup reset and clock sequencer
// Assumes: core clock of 250 MHz, APB registers one word each
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

// clock rate
`define SSQ_CORE_MHZ 250
// reference-cycle counts of the reset sequence
`define SSQ_RELEASE_REF_CYC 13'h1000
`define SSQ_MIN_PULSE_REF_CYC 3'h4
// times in microseconds and their core-cycle counts
`define SSQ_STRAP_SETUP_US 20
`define SSQ_STRAP_SETUP_CYC (`SSQ_STRAP_SETUP_US * `SSQ_CORE_MHZ)
`define SSQ_CLK_VALID_US 10
`define SSQ_CLK_VALID_CYC (`SSQ_CLK_VALID_US * `SSQ_CORE_MHZ)
`define SSQ_PLL_LOCK_US 100
`define SSQ_PLL_LOCK_CYC (`SSQ_PLL_LOCK_US * `SSQ_CORE_MHZ)
// longest reference period in ns, rounded down to core cycles
`define SSQ_REF_MAX_NS 160
`define SSQ_REF_MAX_CYC ((`SSQ_REF_MAX_NS * `SSQ_CORE_MHZ) / 1000)
// register byte offsets
`define SSQ_OFS_POWER_MGMT_CONTROL_REGISTER 12'h000
`define SSQ_OFS_SPIDIV 12'h004
`define SSQ_OFS_SERDIV 12'h008
`define SSQ_OFS_FLAGCTL 12'h00c
`define SSQ_OFS_STATUS 12'h010
`define SSQ_OFS_RATIO 12'h014
// reset values
`define SSQ_RST_PLL_DIVIDER 4'h1
`define SSQ_RST_SPIDIV 16'h0004
`define SSQ_RST_SERDIV 16'h0004
// default multipliers chosen by the clock ratio straps
`define SSQ_MULT_00 8'h10
`define SSQ_MULT_01 8'h20
`define SSQ_MULT_1X 8'h08

`endif

// *** src/ssq_pkg.sv ***
// Purpose: types of the startup reset and clock sequencer
// Assumes: nothing beyond the constants header
// Notes: register fields travel as packed structs
package ssq_pkg;
	typedef enum logic [1:0] {
		SSQ_HELD,
		SSQ_COUNT,
		SSQ_RUN
	} ssq_state_e;

	// power management control register layout
	typedef struct packed {
		logic [18:0] unused;
		logic in_div;
		logic [3:0] pll_divider;
		logic [7:0] pll_multiplier;
	} ssq_power_mgmt_control_register_s;

	// sticky sequencing errors
	typedef struct packed {
		logic pll_short;
		logic clk_late;
		logic strap_late;
		logic short_pulse;
	} ssq_err_s;
endpackage

// *** src/ssq_bitclk_div.sv ***
// Purpose: bit clock whose period is a whole number of core periods
// Assumes: ratio changes take effect at once, even in mid period
// Notes: ratios below two are served as two
`timescale 1ns/1ps
module ssq_bitclk_div #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// period in core cycles
	input wire logic [W-1:0] ratio,
	// generated clock
	output logic bit_clk
);
	generate
		if (W < 2) begin : g_chk
			$error("ssq_bitclk_div needs W of two or more");
		end
	endgenerate

	logic [W-1:0] cnt;
	logic [W-1:0] per;
	logic [W-1:0] next_cnt;
	logic next_bit_clk;

	// a flop cannot toggle faster than every core cycle
	assign per = (ratio < W'(2)) ? W'(2) : ratio;
	assign next_cnt = (cnt >= per - W'(1)) ? '0 : cnt + W'(1);
	assign next_bit_clk = next_cnt < (per >> 1);

	// period counter and output flop
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			bit_clk <= 1'b0;
		end else begin
			cnt <= next_cnt;
			bit_clk <= next_bit_clk;
		end
	end
endmodule // ssq_bitclk_div

// *** bench/ssq_board.sv ***
// Purpose: board reset supervisor and free running reference clock
// Assumes: the bench picks the reference half period
// Notes: pin and straps change on reference rises, far from the falling edges
`timescale 1ns/1ps
module ssq_board #(
	parameter int HALF_NS = 10
) (
	// board pins
	output logic REF_CLK_IN,
	output logic RESET_PIN_N,
	output logic [1:0] CLOCK_RATIO_STRAPS
);
	// reference runs from time zero, well ahead of any release
	initial begin
		REF_CLK_IN = 1'b0;
		RESET_PIN_N = 1'b0;
		CLOCK_RATIO_STRAPS = 2'b01;
		// offset off the core edges so pin sampling never races
		#1;
		forever #(HALF_NS) REF_CLK_IN = ~REF_CLK_IN;
	end
	// pin low for eight reference cycles or more: pulse and lock time
	task automatic pulse(input logic [1:0] s, input int n);
		@(posedge REF_CLK_IN);
		RESET_PIN_N <= 1'b0;
		CLOCK_RATIO_STRAPS <= s; // held until after release
		repeat ((n < 8) ? 8 : n) @(posedge REF_CLK_IN);
		RESET_PIN_N <= 1'b1;
	endtask
endmodule // ssq_board

// *** bench/ssq_sequencer_chk.sv ***
// Purpose: port checks of the startup sequencer
// Assumes: one core clock, synchronous reset
// Notes: reference rises are counted as the core clock sees them
`timescale 1ns/1ps
module ssq_sequencer_chk #(
	parameter int N_AUDIO_IRQ = 1
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// board pins
	input wire logic RESET_PIN_N,
	input wire logic REF_CLK_IN,
	input wire logic [2:0] IRQ_FLAG_IN,
	// core side and bus
	input wire logic CORE_RESET,
	input wire logic [2+N_AUDIO_IRQ:0] IRQ_REQ,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	logic ref_q;
	logic [15:0] n_ref;
	default clocking dc @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	// rises since pin release; may run one ahead of the design's sampling
	always_ff @(posedge CORE_CLK) begin
		ref_q <= REF_CLK_IN;
		if (RST || !RESET_PIN_N)
			n_ref <= 16'h0000;
		else if (REF_CLK_IN && !ref_q && !(&n_ref))
			n_ref <= n_ref + 16'h0001;
	end
	a_core_hold: assert property ($fell(CORE_RESET) |->
		n_ref >= 4096 && n_ref <= 4098) else $error("core reset length");
	a_core_enter: assert property ($fell(RESET_PIN_N) |->
		##[1:16] CORE_RESET) else $error("core reset not entered");
	a_irq_rise: assert property ($rose(IRQ_REQ[0]) |->
		$past(IRQ_FLAG_IN[0], 3) && $past(IRQ_FLAG_IN[0], 4))
		else $error("short request passed");
	a_irq_fall: assert property ($fell(IRQ_FLAG_IN[1]) |->
		##3 !IRQ_REQ[1]) else $error("request outlived input");
	a_apb_wait: assert property (PSEL && $rose(PENABLE) |->
		!PREADY ##1 PREADY) else $error("not one wait state");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
		else $error("ready without access");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	cover property ($fell(CORE_RESET));
	cover property (PSLVERR);
	cover property ($rose(IRQ_REQ[0]));
endmodule // ssq_sequencer_chk

bind ssq_sequencer ssq_sequencer_chk #(.N_AUDIO_IRQ(N_AUDIO_IRQ)) u_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .RESET_PIN_N(RESET_PIN_N),
	.REF_CLK_IN(REF_CLK_IN), .IRQ_FLAG_IN(IRQ_FLAG_IN),
	.CORE_RESET(CORE_RESET), .IRQ_REQ(IRQ_REQ), .PSEL(PSEL),
	.PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR));

// *** bench/ssq_sequencer_bench.sv ***
// Purpose: self-checking bench of the startup sequencer
// Assumes: reference of five core periods, shortened check counts
// Notes: each release costs some 20500 cycles, so only two are timed
`timescale 1ns/1ps
module ssq_sequencer_bench;
	localparam int RP = 5;
	logic clk, rst, rclk, pin_n, f3o, f3oe, tmr, crst, sclk, spck;
	logic psel, pen, pwr, prdy, perr, e;
	logic [1:0] strap;
	logic [3:0] irqv, req;
	logic [11:0] pa;
	logic [31:0] pwd, prd, q;
	int n_fail = 0;
	int checked = 0;
	// flag 3 wire: a pull-up holds it high while nobody drives
	wire f3i = f3oe ? f3o : 1'b1;
	ssq_board u_ssq_board (.REF_CLK_IN(rclk), .RESET_PIN_N(pin_n),
		.CLOCK_RATIO_STRAPS(strap));
	ssq_sequencer #(.STRAP_SETUP_CYC(20), .CLK_VALID_CYC(10),
		.PLL_LOCK_CYC(30)) u_ssq_sequencer (.CORE_CLK(clk), .RST(rst),
		.RESET_PIN_N(pin_n), .REF_CLK_IN(rclk), .CLOCK_RATIO_STRAPS(strap),
		.IRQ_FLAG_IN(irqv[2:0]), .AUDIO_IRQ_IN(irqv[3]), .GENERAL_FLAG_PIN_3_I(f3i),
		.GENERAL_FLAG_PIN_3_O(f3o), .GENERAL_FLAG_PIN_3_OE(f3oe), .CORE_TIMER_IN(tmr),
		.CORE_RESET(crst), .IRQ_REQ(req), .SERIAL_BIT_CLK(sclk),
		.SPI_BIT_CLK(spck), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
		.PSLVERR(perr));
	// core clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// verdict, from the end of the run or from a timeout
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("unexpected at %0t: %h, not %h", $time, g, x);
		end
	endtask
	task automatic hang();
		chk(0, 1);
		wrap_up();
	endtask
	// one transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		{psel, pwr, pa, pwd} <= {1'b1, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		for (k = 0; k < 20 && prdy !== 1'b1; k++)
			@(posedge clk);
		{q, e} = {prd, perr};
		{psel, pen} <= 2'b00;
		@(posedge clk);
		if (k == 20)
			hang();
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// release the pin, time the core reset; writes meanwhile are dropped
	task automatic t_release(input logic [1:0] s, input logic [7:0] m);
		time t0;
		int c;
		logic [31:0] v;
		u_ssq_board.pulse(s, 8);
		t0 = $time;
		@(posedge clk);
		apb(1'b0, 12'h004, 32'h0);
		v = q;
		apb(1'b1, 12'h004, 32'h0000_0009);
		rd(12'h004, v);
		for (c = 0; c < 30000 && crst !== 1'b0; c++)
			@(posedge clk);
		if (crst !== 1'b0)
			hang();
		c = int'(($time - t0) / 4);
		chk(c >= 4096 * RP && c <= 4097 * RP + 15, 1);
		apb(1'b0, 12'h000, 32'h0);
		chk(q[7:0], m);
	endtask
	// rise-to-rise period, measured once the new ratio has landed
	task automatic t_period(input logic s, input int want);
		int k, n, t2;
		logic p, v;
		n = 0;
		t2 = 0;
		p = 1'b1;
		for (k = 0; k < 300 && n < 3; k++) begin
			@(posedge clk);
			v = s ? spck : sclk;
			if (v && !p)
				n++;
			if (v && !p && n == 2)
				t2 = k;
			p = v;
		end
		chk(k - 1 - t2, want);
	endtask
	// pulse one request line for len cycles, see whether it is taken
	task automatic t_irq(input int i, input int len, input logic want);
		logic seen;
		seen = 1'b0;
		irqv[i] <= 1'b1;
		repeat (len) @(posedge clk);
		irqv[i] <= 1'b0;
		repeat (8) begin
			@(posedge clk);
			seen = seen | req[i];
		end
		chk(seen, want);
	endtask
	// timer routed to flag 3 and driven out
	task automatic t_general_flag_pin_3();
		apb(1'b1, 12'h00c, 32'h0000_0003);
		tmr <= 1'b1;
		repeat (4) @(posedge clk);
		chk({f3oe, f3o}, 2'b11);
		tmr <= 1'b0;
		repeat (4) @(posedge clk);
		chk({f3oe, f3o}, 2'b10);
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		{psel, pen, pwr, tmr} = 4'h0;
		{pa, pwd, irqv} = 48'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_release(2'b01, 8'h20);
		rd(12'h010, 32'h0000_0020);
		rd(12'h008, 32'h0000_0004);
		rd(12'h014, 32'h0002_0040);
		apb(1'b1, 12'h000, 32'h0000_1210); // core period 5 ns
		rd(12'h014, 32'h0004_0010);
		rd(12'h018, 32'h0);
		chk(e, 1);
		apb(1'b1, 12'h004, 32'h0000_0006);
		t_period(1'b1, 6);
		apb(1'b1, 12'h004, 32'h0000_0001);
		t_period(1'b1, 2);
		apb(1'b1, 12'h008, 32'h0000_000a);
		t_period(1'b0, 10);
		for (int i = 0; i < 4; i++) begin
			t_irq(i, 1, 1'b0);
			t_irq(i, 2, 1'b1);
		end
		t_general_flag_pin_3();
		u_ssq_board.pulse(2'b10, 8);
		repeat (200) @(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		chk(q[7:0], 8'h08);
		rd(12'h010, 32'h0000_0001);
		t_release(2'b00, 8'h10);
		wrap_up();
	end
endmodule // ssq_sequencer_bench
